// *** sse_status_encoder.sv ***
// What this block does
// RULE_01: bus error gives 0x00; sent START gives 0x08, repeated START 0x10.
// RULE_02: master write address acked gives 0x18, not acked gives 0x20.
// RULE_03: master data acked 0x28, not acked 0x30; arbitration lost 0x38.
// RULE_04: master read address acked gives 0x40, not acked gives 0x48.
// RULE_05: master received byte with ack 0x50, without ack 0x58.
// RULE_06: own address with write received and acked gives 0x60.
// RULE_07: addressed after losing arbitration in address: 0x68, 0x78, 0xB0.
// RULE_08: general call address received and acked gives 0x70.
// RULE_09: own-address slave receiver data acked 0x80, not acked 0x88.
// RULE_10: general call data acked 0x90, not acked 0x98.
// RULE_11: STOP or repeated START while addressed as slave gives 0xA0.
// RULE_12: own address with read received and acked gives 0xA8.
// RULE_13: slave transmit acked 0xB8, not acked 0xC0, last byte acked 0xC8.
// RULE_14: SCL high too long in slave modes gives 0xD0; idle gives 0xF8.
// RULE_15: low three code bits read zero while the event flag is set.
// RULE_16: general call recognised only when own address bit 0 is one.
// RULE_17: software reads the code only while flag set, never writes it.
// RULE_18: code loads in the same cycle the event flag is set.
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "sse_map.svh"

// ********************************
// status fifo
// ********************************
module sse_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    // fill side
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);
    localparam int CW = $clog2(DEPTH + 1);

    // head always at index 0 so the output is a flop
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             push;
    logic             pop;
    logic             nfull_q;
    logic             nempty_q;

    assign push          = in_valid_in && nfull_q;
    assign pop           = out_ready_in && nempty_q;
    assign in_ready_out  = nfull_q;
    assign out_valid_out = nempty_q;
    assign out_data_out  = mem_q[0];

    always_comb begin
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + CW'(1);
        end else if (pop && !push) begin
            cnt_d = cnt_q - CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q    <= '0;
            nfull_q  <= 1'b1;
            nempty_q <= 1'b0;
        end else if (ce_in) begin
            cnt_q    <= cnt_d;
            nfull_q  <= (cnt_d != CW'(DEPTH));
            nempty_q <= (cnt_d != '0);
        end
    end

    for (genvar i = 0; i < DEPTH; i++) begin : g_slot
        always_ff @(posedge clk_in) begin
            if (!rst_n_in) begin
                mem_q[i] <= '0;
            end else if (ce_in) begin
                if (push && (CW'(i) == (pop ? cnt_q - CW'(1) : cnt_q))) begin
                    mem_q[i] <= in_data_in;
                end else if (pop && (i < DEPTH - 1)) begin
                    mem_q[i] <= mem_q[(i < DEPTH - 1) ? i + 1 : i];
                end
            end
        end
    end
endmodule : sse_fifo

// ********************************
// status encoder top
// ********************************
module sse_status_encoder (
    // clock, reset, enable
    input  wire logic              MCLK_IN,
    input  wire logic              RESET_N_IN,
    input  wire logic              CE_IN,
    // register port
    input  wire logic [2:0]        ADDR_IN,
    input  wire logic [7:0]        WR_DATA_IN,
    input  wire logic              WR_EN_IN,
    input  wire logic              RD_EN_IN,
    output logic      [7:0]        RD_DATA_OUT,
    // bus pins, sampled
    input  wire logic              SCL_IN,
    input  wire logic              SDA_IN,
    // events from the shift engine
    input  wire logic              EVT_VALID_IN,
    input  wire sse_pkg::sse_evt_t EVT_IN,
    output logic                   EVT_READY_OUT,
    // status stream
    output logic                   STAT_VALID_OUT,
    input  wire logic              STAT_READY_IN,
    output logic      [7:0]        STAT_CODE_OUT,
    output logic                   SERIAL_FLAG_OUT
);
    localparam int UNIT_CYC = (`SSE_TMO_UNIT_NS + `SSE_CLK_PERIOD_NS - 1) / `SSE_CLK_PERIOD_NS;

    logic                scl_m_q, scl_s_q, scl_d_q;
    logic                sda_m_q, sda_s_q, sda_d_q;
    logic                start_det, stop_det;
    logic [7:0]          own_q;
    logic                tmo_en_q;
    logic                aa_q;
    logic [7:0]          limit_q;
    logic                flag_q;
    logic [7:0]          code_q;
    logic [7:0]          rd_q;
    sse_pkg::sse_state_t state_q, state_d;
    logic                a0_pend_q, tmo_pend_q;
    logic                tmo_lock_q;
    logic [6:0]          unit_q;
    logic [7:0]          high_q;
    logic                addressed;
    logic                fifo_rdy;
    logic                commit, take_evt, take_a0, take_tmo;
    logic [7:0]          commit_code;
    logic [7:0]          idle_code;
    sse_pkg::sse_step_t  step;

    // ********************************
    // pin synchronisers
    // ********************************
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            {scl_m_q, scl_s_q, scl_d_q} <= 3'h7;
            {sda_m_q, sda_s_q, sda_d_q} <= 3'h7;
        end else if (CE_IN) begin
            {scl_m_q, scl_s_q, scl_d_q} <= {SCL_IN, scl_m_q, scl_s_q};
            {sda_m_q, sda_s_q, sda_d_q} <= {SDA_IN, sda_m_q, sda_s_q};
        end
    end

    assign start_det = scl_s_q && scl_d_q && sda_d_q && !sda_s_q;
    assign stop_det  = scl_s_q && scl_d_q && !sda_d_q && sda_s_q;
    assign addressed = (state_q == sse_pkg::S_SRXO) || (state_q == sse_pkg::S_SRXG)
                    || (state_q == sse_pkg::S_STX);

    // ********************************
    // event decode
    // ********************************
    function automatic sse_pkg::sse_step_t decode_evt(
        input sse_pkg::sse_state_t st,
        input sse_pkg::sse_evt_t   ev,
        input logic [7:0]          own,
        input logic                aa
    );
        sse_pkg::sse_step_t r;
        logic               arb;
        logic               gc_hit;
        logic               own_hit;
        r.hit   = 1'b1;
        r.st    = st;
        r.code  = `SSE_ST_IDLE;
        arb     = (st == sse_pkg::S_ARBL);
        gc_hit  = (ev.data == `SSE_GC_ADDR) && own[`SSE_OWN_GC_BIT];   // [RULE_16]
        own_hit = (ev.data[7:1] == own[7:1]) && (ev.data != `SSE_GC_ADDR);
        case (ev.kind)
            sse_pkg::EV_BUS_ERROR: begin
                r.code = `SSE_ST_BUSERR;                                // [RULE_01]
                r.st   = sse_pkg::S_IDLE;
            end
            sse_pkg::EV_START: begin
                r.code = `SSE_ST_START;                                 // [RULE_01]
                r.st   = sse_pkg::S_MADDR;
            end
            sse_pkg::EV_RSTART: begin
                r.code = `SSE_ST_RSTART;                                // [RULE_01]
                r.st   = sse_pkg::S_MADDR;
            end
            sse_pkg::EV_ADDR_SENT: begin
                if (ev.rw) begin
                    r.code = ev.ack ? `SSE_ST_MR_AACK : `SSE_ST_MR_ANACK;   // [RULE_04]
                    r.st   = ev.ack ? sse_pkg::S_MRX : sse_pkg::S_MADDR;
                end else begin
                    r.code = ev.ack ? `SSE_ST_MT_AACK : `SSE_ST_MT_ANACK;   // [RULE_02]
                    r.st   = ev.ack ? sse_pkg::S_MTX : sse_pkg::S_MADDR;
                end
            end
            sse_pkg::EV_DATA_SENT: begin
                if (st == sse_pkg::S_STX) begin
                    r.code = !ev.ack ? `SSE_ST_ST_DNACK :
                             (aa ? `SSE_ST_ST_DACK : `SSE_ST_ST_LAST);      // [RULE_13]
                end else begin
                    r.code = ev.ack ? `SSE_ST_MT_DACK : `SSE_ST_MT_DNACK;   // [RULE_03]
                end
            end
            sse_pkg::EV_ARB_LOST: begin
                r.code = `SSE_ST_ARB_LOST;                              // [RULE_03]
                r.st   = (st == sse_pkg::S_MADDR) ? sse_pkg::S_ARBL : sse_pkg::S_IDLE;
            end
            sse_pkg::EV_DATA_RECV: begin
                case (st)
                    sse_pkg::S_SRXO: r.code = ev.ack ? `SSE_ST_SR_DACK : `SSE_ST_SR_DNACK; // [RULE_09]
                    sse_pkg::S_SRXG: r.code = ev.ack ? `SSE_ST_GC_DACK : `SSE_ST_GC_DNACK; // [RULE_10]
                    default:         r.code = ev.ack ? `SSE_ST_MR_DACK : `SSE_ST_MR_DNACK; // [RULE_05]
                endcase
            end
            sse_pkg::EV_ADDR_RECV: begin
                if (gc_hit) begin
                    r.code = arb ? `SSE_ST_SR_GC_ARB : `SSE_ST_SR_GC;       // [RULE_07] [RULE_08]
                    r.st   = sse_pkg::S_SRXG;
                end else if (own_hit && !ev.data[0]) begin
                    r.code = arb ? `SSE_ST_SR_OWN_ARB : `SSE_ST_SR_OWN;     // [RULE_06] [RULE_07]
                    r.st   = sse_pkg::S_SRXO;
                end else if (own_hit) begin
                    r.code = arb ? `SSE_ST_ST_OWN_ARB : `SSE_ST_ST_OWN;     // [RULE_07] [RULE_12]
                    r.st   = sse_pkg::S_STX;
                end else begin
                    r.hit  = 1'b0;
                    r.st   = sse_pkg::S_IDLE;
                end
            end
            default: begin
                r.hit = 1'b0;
            end
        endcase
        return r;
    endfunction : decode_evt

    assign step = decode_evt(state_q, EVT_IN, own_q, aa_q);

    // ********************************
    // event arbitration
    // ********************************
    // engine events first; a pending timeout waits, a pending 0xA0 is cleared when an engine event is taken
    always_comb begin
        take_evt    = 1'b0;
        take_a0     = 1'b0;
        take_tmo    = 1'b0;
        commit      = 1'b0;
        commit_code = code_q;
        state_d     = state_q;
        idle_code   = code_q;
        if (EVT_VALID_IN && fifo_rdy) begin
            take_evt = 1'b1;
            state_d  = step.st;
            if (step.hit) begin
                commit      = 1'b1;
                commit_code = step.code;
            end
        end else if (a0_pend_q && fifo_rdy) begin
            take_a0     = 1'b1;
            commit      = 1'b1;
            commit_code = `SSE_ST_SL_STOP;                              // [RULE_11]
            state_d     = sse_pkg::S_IDLE;
        end else if (tmo_pend_q && fifo_rdy) begin
            take_tmo    = 1'b1;
            commit      = 1'b1;
            commit_code = `SSE_ST_TIMEOUT;                              // [RULE_14]
        end else if (stop_det && !addressed && !a0_pend_q) begin
            state_d   = sse_pkg::S_IDLE;
            idle_code = `SSE_ST_IDLE;                                   // [RULE_14]
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            state_q <= sse_pkg::S_IDLE;
            code_q  <= `SSE_ST_IDLE;
        end else if (CE_IN) begin
            state_q <= state_d;
            code_q  <= commit ? commit_code : idle_code;                // [RULE_18]
        end
    end

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            a0_pend_q <= 1'b0;
        end else if (CE_IN) begin
            if ((start_det || stop_det) && addressed) begin
                a0_pend_q <= 1'b1;                                      // [RULE_11]
            end else if (take_a0 || take_evt) begin
                a0_pend_q <= 1'b0;
            end
        end
    end

    // ********************************
    // scl high timeout
    // ********************************
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            unit_q     <= '0;
            high_q     <= '0;
            tmo_lock_q <= 1'b0;
        end else if (CE_IN) begin
            if (!scl_s_q || !tmo_en_q || !addressed) begin
                unit_q     <= '0;
                high_q     <= '0;
                tmo_lock_q <= 1'b0;
            end else if (unit_q == 7'(UNIT_CYC - 1)) begin
                unit_q <= '0;
                if (high_q != 8'hff) begin
                    high_q <= high_q + 8'h01;
                end
            end else begin
                unit_q <= unit_q + 7'h01;
            end
            if (tmo_pend_q) begin
                tmo_lock_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            tmo_pend_q <= 1'b0;
        end else if (CE_IN) begin
            if (tmo_en_q && addressed && scl_s_q && !tmo_lock_q && !tmo_pend_q
                && (limit_q != 8'h00) && (high_q >= limit_q)) begin
                tmo_pend_q <= 1'b1;                                     // [RULE_14]
            end else if (take_tmo) begin
                tmo_pend_q <= 1'b0;
            end
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            own_q    <= `SSE_RST_OWN;
            tmo_en_q <= 1'b0;
            aa_q     <= 1'b1;
            limit_q  <= `SSE_RST_LIMIT;
        end else if (CE_IN && WR_EN_IN) begin
            case (ADDR_IN)
                `SSE_OFS_OWN: own_q <= WR_DATA_IN;
                `SSE_OFS_CTRL: begin
                    tmo_en_q <= WR_DATA_IN[`SSE_CTRL_TMO_BIT];
                    aa_q     <= WR_DATA_IN[`SSE_CTRL_AA_BIT];
                end
                `SSE_OFS_LIMIT: limit_q <= WR_DATA_IN;
                default: begin
                end
            endcase
        end
    end

    // status code writes are dropped on purpose
    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            flag_q <= 1'b0;
        end else if (CE_IN) begin
            if (commit) begin
                flag_q <= 1'b1;                                         // [RULE_18]
            end else if (WR_EN_IN && (ADDR_IN == `SSE_OFS_FLAG)
                         && !WR_DATA_IN[`SSE_FLAG_BIT]) begin
                flag_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RESET_N_IN) begin
            rd_q <= 8'h00;
        end else if (CE_IN) begin
            rd_q <= 8'h00;
            if (RD_EN_IN) begin
                case (ADDR_IN)
                    `SSE_OFS_CODE:  rd_q <= {code_q[7:3], flag_q ? 3'h0 : code_q[2:0]}; // [RULE_15]
                    `SSE_OFS_FLAG:  rd_q <= {7'h00, flag_q};
                    `SSE_OFS_OWN:   rd_q <= own_q;
                    `SSE_OFS_CTRL:  rd_q <= {6'h00, aa_q, tmo_en_q};
                    `SSE_OFS_LIMIT: rd_q <= limit_q;
                    default:        rd_q <= 8'h00;
                endcase
            end
        end
    end

    // ********************************
    // status stream
    // ********************************
    sse_fifo #(
        .WIDTH (8),
        .DEPTH (4)
    ) u_fifo (
        .clk_in        (MCLK_IN),
        .rst_n_in      (RESET_N_IN),
        .ce_in         (CE_IN),
        .in_valid_in   (commit),
        .in_ready_out  (fifo_rdy),
        .in_data_in    (commit_code),
        .out_valid_out (STAT_VALID_OUT),
        .out_ready_in  (STAT_READY_IN),
        .out_data_out  (STAT_CODE_OUT)
    );

    assign EVT_READY_OUT   = fifo_rdy;
    assign RD_DATA_OUT     = rd_q;
    assign SERIAL_FLAG_OUT = flag_q;

    // ********************************
    // checks
    // ********************************
    sequence s_took(sse_pkg::sse_kind_t k);
        CE_IN && EVT_VALID_IN && fifo_rdy && (EVT_IN.kind == k);
    endsequence

    property p_start;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_START) |=> (code_q == 8'h08) && flag_q;
    endproperty
    a_start: assert property (p_start) else $error("start code wrong"); // [RULE_01]

    property p_addr_w;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_ADDR_SENT) and (!EVT_IN.rw) |=>
            code_q == ($past(EVT_IN.ack) ? 8'h18 : 8'h20);
    endproperty
    a_addr_w: assert property (p_addr_w) else $error("write address code wrong"); // [RULE_02]

    property p_arb;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_ARB_LOST) |=> code_q == 8'h38;
    endproperty
    a_arb: assert property (p_arb) else $error("arbitration code wrong"); // [RULE_03]

    property p_addr_r;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_ADDR_SENT) and EVT_IN.rw && EVT_IN.ack |=>
            (code_q == 8'h40) && (state_q == sse_pkg::S_MRX);
    endproperty
    a_addr_r: assert property (p_addr_r) else $error("read address code wrong"); // [RULE_04]

    property p_mrx;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_DATA_RECV) and (state_q == sse_pkg::S_MRX) |=>
            code_q == ($past(EVT_IN.ack) ? 8'h50 : 8'h58);
    endproperty
    a_mrx: assert property (p_mrx) else $error("master receive code wrong"); // [RULE_05]

    property p_gc_off;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        s_took(sse_pkg::EV_ADDR_RECV) and (EVT_IN.data == 8'h00) && !own_q[0] |=>
            state_q != sse_pkg::S_SRXG;
    endproperty
    a_gc_off: assert property (p_gc_off) else $error("general call not ignored"); // [RULE_16]

    property p_a0;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        CE_IN && a0_pend_q && !EVT_VALID_IN && fifo_rdy |=>
            (code_q == 8'hA0) && flag_q && (state_q == sse_pkg::S_IDLE);
    endproperty
    a_a0: assert property (p_a0) else $error("slave stop code wrong"); // [RULE_11]

    property p_low;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        CE_IN && RD_EN_IN && (ADDR_IN == 3'h0) && flag_q |=> RD_DATA_OUT[2:0] == 3'h0;
    endproperty
    a_low: assert property (p_low) else $error("low code bits not zero"); // [RULE_15]

    property p_flag_code;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        CE_IN && commit |=> flag_q && (code_q == $past(commit_code)) ##1 1'b1;
    endproperty
    a_flag_code: assert property (p_flag_code) else $error("flag and code apart"); // [RULE_18]

    property p_tmo;
        @(posedge MCLK_IN) disable iff (!RESET_N_IN)
        CE_IN && take_tmo |=> (code_q == 8'hD0) && addressed;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout code wrong"); // [RULE_14]
endmodule : sse_status_encoder

// *** sse_map.svh ***
`ifndef SSE_MAP_SVH
`define SSE_MAP_SVH

// ********************************
// register offsets
// ********************************
`define SSE_OFS_CODE       3'h0
`define SSE_OFS_FLAG       3'h1
`define SSE_OFS_OWN        3'h2
`define SSE_OFS_CTRL       3'h3
`define SSE_OFS_LIMIT      3'h4

// ********************************
// field positions and reset values
// ********************************
`define SSE_FLAG_BIT       0
`define SSE_CTRL_TMO_BIT   0
`define SSE_CTRL_AA_BIT    1
`define SSE_OWN_GC_BIT     0
`define SSE_RST_OWN        8'h00
`define SSE_RST_LIMIT      8'h00

// ********************************
// status codes
// ********************************
`define SSE_ST_BUSERR      8'h00
`define SSE_ST_START       8'h08
`define SSE_ST_RSTART      8'h10
`define SSE_ST_MT_AACK     8'h18
`define SSE_ST_MT_ANACK    8'h20
`define SSE_ST_MT_DACK     8'h28
`define SSE_ST_MT_DNACK    8'h30
`define SSE_ST_ARB_LOST    8'h38
`define SSE_ST_MR_AACK     8'h40
`define SSE_ST_MR_ANACK    8'h48
`define SSE_ST_MR_DACK     8'h50
`define SSE_ST_MR_DNACK    8'h58
`define SSE_ST_SR_OWN      8'h60
`define SSE_ST_SR_OWN_ARB  8'h68
`define SSE_ST_SR_GC       8'h70
`define SSE_ST_SR_GC_ARB   8'h78
`define SSE_ST_SR_DACK     8'h80
`define SSE_ST_SR_DNACK    8'h88
`define SSE_ST_GC_DACK     8'h90
`define SSE_ST_GC_DNACK    8'h98
`define SSE_ST_SL_STOP     8'hA0
`define SSE_ST_ST_OWN      8'hA8
`define SSE_ST_ST_OWN_ARB  8'hB0
`define SSE_ST_ST_DACK     8'hB8
`define SSE_ST_ST_DNACK    8'hC0
`define SSE_ST_ST_LAST     8'hC8
`define SSE_ST_TIMEOUT     8'hD0
`define SSE_ST_IDLE        8'hF8
`define SSE_GC_ADDR        8'h00

// ********************************
// timing
// ********************************
`define SSE_CLK_PERIOD_NS  8
`define SSE_TMO_UNIT_NS    1000

`endif

// *** sse_pkg.sv ***
package sse_pkg;

    typedef enum logic [2:0] {
        S_IDLE  = 3'h0,
        S_MADDR = 3'h1,
        S_MTX   = 3'h3,
        S_MRX   = 3'h2,
        S_ARBL  = 3'h6,
        S_SRXO  = 3'h7,
        S_SRXG  = 3'h5,
        S_STX   = 3'h4
    } sse_state_t;

    typedef enum logic [3:0] {
        EV_NONE      = 4'h0,
        EV_START     = 4'h1,
        EV_RSTART    = 4'h2,
        EV_ADDR_SENT = 4'h3,
        EV_DATA_SENT = 4'h4,
        EV_ARB_LOST  = 4'h5,
        EV_DATA_RECV = 4'h6,
        EV_ADDR_RECV = 4'h7,
        EV_BUS_ERROR = 4'h8
    } sse_kind_t;

    typedef struct packed {
        sse_kind_t  kind;
        logic       ack;
        logic       rw;
        logic [7:0] data;
    } sse_evt_t;

    typedef struct packed {
        logic       hit;
        sse_state_t st;
        logic [7:0] code;
    } sse_step_t;

endpackage : sse_pkg

// *** sse_bus_peer.sv ***
`timescale 1ns/1ps
// ****
// peer on the shared bus, lines idle high as driven by the peer
// ****
module sse_bus_peer (
    // bus lines
    output logic scl_out,
    output logic sda_out
);
    initial scl_out = 1'b1;
    initial sda_out = 1'b1;
    // scl pulses only inside the frame, link rate 125 ns
    task automatic stop_cond();
        #62.5 scl_out = 1'b0;
        sda_out = 1'b0;
        #62.5 scl_out = 1'b1;
        #62.5 sda_out = 1'b1;
        #500;
    endtask : stop_cond
endmodule : sse_bus_peer

// *** tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, v) begin num_checks++; if ((v) !== (e)) begin errors++; \
    $display("unexpected %s exp %h seen %h", n, e, v); end end
// ****
// status encoder bench
// ****
module tb;
    logic clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ev_v = 1'b0, s_rdy = 1'b1;
    logic              ce = 1'b1;
    logic [2:0]        addr = 3'h0;
    logic [7:0]        wdat = 8'h00;
    sse_pkg::sse_evt_t ev_d = '0;
    wire               scl, sda, ev_rdy, s_v, flag;
    wire [7:0]         rdat, s_code;
    int                errors = 0, num_checks = 0, n;
    logic [7:0]        arb_e [3] = '{8'h68, 8'h78, 8'hb0};
    logic [7:0]        arb_a [3] = '{8'ha4, 8'h00, 8'ha5};
    logic [2:0]        arb_r = 3'b100;
    sse_status_encoder uut (.MCLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce),
        .ADDR_IN(addr), .WR_DATA_IN(wdat), .WR_EN_IN(wr_en), .RD_EN_IN(rd_en),
        .RD_DATA_OUT(rdat), .SCL_IN(scl), .SDA_IN(sda), .EVT_VALID_IN(ev_v),
        .EVT_IN(ev_d), .EVT_READY_OUT(ev_rdy), .STAT_VALID_OUT(s_v),
        .STAT_READY_IN(s_rdy), .STAT_CODE_OUT(s_code), .SERIAL_FLAG_OUT(flag));
    sse_bus_peer peer (.scl_out(scl), .sda_out(sda));
    initial forever #4 clk = ~clk;
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= w;
        rd_en <= !w;
        addr  <= a;
        wdat  <= d;
        @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
    endtask : bus
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        #1 `CHK("rd_data", e, rdat)
    endtask : rd
    task automatic put(input logic [3:0] k, input logic a, r, input logic [7:0] d);
        @(posedge clk);
        ev_v <= 1'b1;
        ev_d <= '{sse_pkg::sse_kind_t'(k), a, r, d};
        @(posedge clk);
        for (int i = 0; i < 50 && ev_rdy !== 1'b1; i++) @(posedge clk);
        ev_v <= 1'b0;
    endtask : put
    task automatic ev(input logic [3:0] k, input logic [7:0] e, input logic a = 1'b1,
                      input logic r = 1'b0, input logic [7:0] d = 8'h00);
        put(k, a, r, d);
        // head stands one cycle only while the drain side is ready
        #1 `CHK("flag", 1'b1, flag)
        `CHK("stream_valid", 1'b1, s_v)
        `CHK("stream", e, s_code)
        rd(3'h0, e);
        bus(1'b1, 3'h1, 8'h00);
    endtask : ev
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(3'h0, 8'hf8);
        rd(3'h3, 8'h02);
        rd(3'h7, 8'h00);
        bus(1'b1, 3'h5, 8'h55);
        rd(3'h0, 8'hf8);
        ev(4'h1, 8'h08);
        ev(4'h3, 8'h18);
        ev(4'h4, 8'h28);
        ev(4'h4, 8'h30, 1'b0);
        ev(4'h2, 8'h10);
        ev(4'h3, 8'h40, 1'b1, 1'b1);
        ev(4'h6, 8'h50);
        ev(4'h6, 8'h58, 1'b0);
        ev(4'h2, 8'h10);
        ev(4'h3, 8'h20, 1'b0);
        ev(4'h2, 8'h10);
        ev(4'h3, 8'h48, 1'b0, 1'b1);
        ev(4'h8, 8'h00);
        bus(1'b1, 3'h2, 8'ha5);
        ev(4'h7, 8'h60, 1'b1, 1'b0, 8'ha4);
        ev(4'h6, 8'h80);
        peer.stop_cond();
        rd(3'h0, 8'ha0);
        ev(4'h7, 8'h60, 1'b1, 1'b0, 8'ha4);
        ev(4'h6, 8'h88, 1'b0);
        ev(4'h8, 8'h00);
        ev(4'h7, 8'ha8, 1'b1, 1'b1, 8'ha5);
        ev(4'h4, 8'hb8);
        bus(1'b1, 3'h3, 8'h00);
        ev(4'h4, 8'hc8);
        bus(1'b1, 3'h3, 8'h02);
        ev(4'h4, 8'hc0, 1'b0);
        ev(4'h8, 8'h00);
        ev(4'h7, 8'h70, 1'b1, 1'b0, 8'h00);
        ev(4'h6, 8'h90);
        ev(4'h6, 8'h98, 1'b0);
        for (int i = 0; i < 3; i++) begin
            ev(4'h8, 8'h00);
            ev(4'h1, 8'h08);
            ev(4'h5, 8'h38);
            ev(4'h7, arb_e[i], 1'b1, arb_r[i], arb_a[i]);
        end
        ev(4'h8, 8'h00);
        bus(1'b1, 3'h2, 8'ha4);
        put(4'h7, 1'b1, 1'b0, 8'h00);
        peer.stop_cond();
        `CHK("flag", 1'b0, flag)
        rd(3'h0, 8'hf8);
        bus(1'b1, 3'h4, 8'h01);
        bus(1'b1, 3'h3, 8'h03);
        ev(4'h7, 8'h60, 1'b1, 1'b0, 8'ha4);
        repeat (140) @(posedge clk);
        rd(3'h0, 8'hd0);
        bus(1'b1, 3'h3, 8'h02);
        s_rdy <= 1'b0;
        repeat (4) ev(4'h8, 8'h00);
        `CHK("evt_ready", 1'b0, ev_rdy)
        @(posedge clk) s_rdy <= 1'b1;
        n = 0;
        repeat (6) begin
            @(posedge clk);
            n += (s_v === 1'b1);
        end
        `CHK("drained", 4, n)
        // enable low: an offered event must leave no trace
        ce <= 1'b0;
        put(4'h1, 1'b1, 1'b0, 8'h00);
        #1 `CHK("frozen_flag", 1'b0, flag)
        `CHK("frozen_stream", 1'b0, s_v)
        @(posedge clk) ce <= 1'b1;
        end_of_test();
    end
endmodule : tb
